// ==== hw/pnss_clock_gen.sv ====
// chip and bit tick generator derived from the selected reference ticks
module pnss_clock_gen (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic clear_in,
	input wire logic ref_tick_in,
	input wire logic ratio_mode_in,
	input wire logic [7:0] divider_in,
	input wire logic [7:0] len_in,
	output logic chip_tick_out,
	output logic bit_tick_out
);
	// bit period in reference ticks; a zero length or divider is taken as a base of 256, before the length-mode shift
	function automatic logic [11:0] bit_period(input logic ratio, input logic [7:0] div,
		input logic [7:0] len);
		logic [11:0] base;
		base = (ratio ? div : len) == 8'h00 ? 12'h100 : {4'h0, (ratio ? div : len)};
		if (ratio) begin
			bit_period = base;
		end else begin
			bit_period = base << div[1:0];
		end
	endfunction

	logic [1:0] quarter_q;
	logic [11:0] ref_cnt_q;
	wire logic [11:0] period = bit_period(ratio_mode_in, divider_in, len_in);
	wire logic quarter_mode = !ratio_mode_in && divider_in[pnss_pkg::DIV_QUARTER_BIT];
	wire logic bit_wrap = ref_cnt_q == period - 12'h001;

	// ticks are strobes; with clear held the whole chain stands still
	assign chip_tick_out = !clear_in && ref_tick_in &&
		(!quarter_mode || quarter_q == pnss_pkg::QUARTER_LAST);
	assign bit_tick_out = !clear_in && ref_tick_in && bit_wrap;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			quarter_q <= 2'h0;
			ref_cnt_q <= 12'h000;
		end else if (clear_in) begin
			quarter_q <= 2'h0;
			ref_cnt_q <= 12'h000;
		end else if (ref_tick_in) begin
			quarter_q <= quarter_q + 2'h1;
			ref_cnt_q <= bit_wrap ? 12'h000 : ref_cnt_q + 12'h001;
		end
	end
endmodule

// ==== hw/pnss_code_rom.sv ====
// 256-chip code store read as a circular buffer
module pnss_code_rom (
	input wire logic [7:0] addr_in,
	output logic chip_out
);
	// the image lives in an array so a mask option only touches the package
	logic rom_mem [256];

	always_comb begin
		for (int i = 0; i < 256; i++) begin
			rom_mem[i] = pnss_pkg::ROM_IMAGE[i];
		end
	end

	// combinational lookup; the caller registers the result
	assign chip_out = rom_mem[addr_in];
endmodule

// ==== hw/pnss_pkg.sv ====
// shared constants and types for the pseudorandom-code spreading modulator
package pnss_pkg;
	// register offsets on the cpu register port
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_START = 3'h1;
	localparam logic [2:0] OFS_LEN = 3'h2;
	localparam logic [2:0] OFS_HOLD_LO = 3'h3;
	localparam logic [2:0] OFS_HOLD_HI = 3'h4;
	localparam logic [2:0] OFS_DIV = 3'h5;
	// spreader_control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_REF_LSB = 1;
	localparam int CTRL_CHIPOUT_BIT = 3;
	localparam int CTRL_UNSPREAD_BIT = 4;
	localparam int CTRL_BITCLK_BIT = 5;
	localparam int CTRL_RUN_BIT = 6;
	localparam int CTRL_RATIO_BIT = 7;
	// bit_clock_divider field positions
	localparam int DIV_QUARTER_BIT = 2;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] HOLD_RESET = 16'h0000;
	// word and byte sequencing
	localparam logic [3:0] WORD_LAST_BIT = 4'hF;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	// reference clock choice
	typedef enum logic [1:0] {
		PNSS_REF_SYS = 2'b00,
		PNSS_REF_TIMER0 = 2'b01,
		PNSS_REF_TIMER1 = 2'b10,
		PNSS_REF_NONE = 2'b11
	} pnss_ref_t;
	// sequencer states
	typedef enum logic [1:0] {
		PNSS_IDLE = 2'b00,
		PNSS_ARMED = 2'b01,
		PNSS_RUN = 2'b10
	} pnss_state_t;
	// mask-programmed code image, bit n is chip n; contents are arbitrary
	localparam logic [255:0] ROM_IMAGE =
		256'hB5E3_1C47_9A2D_F068_4E71_C3A9_0D5B_62F8_17AC_E94B_3F20_D586_7C1E_A3D4_58B9_206F;
endpackage

// ==== hw/pnss_spreader.sv ====
// direct-sequence spreading modulator with register port and pin muxing
module pnss_spreader (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	output logic [7:0] reg_rdata_out,
	input wire logic code_only_select_in,
	input wire logic counter_timer_zero_in,
	input wire logic counter_timer_one_in,
	input wire logic refill_clear_in,
	input wire logic port2_bit0_output_enable_in,
	input wire logic port2_bit7_output_enable_in,
	output logic refill_request_out,
	output logic port3_bit5_pin_out,
	output logic port3_bit5_pin_oe_out,
	output logic port3_bit6_pin_out,
	output logic port3_bit6_pin_oe_out,
	output logic port2_bit0_pin_out,
	output logic port2_bit0_pin_oe_out,
	output logic port2_bit7_pin_out,
	output logic port2_bit7_pin_oe_out
);
	// register file
	logic [7:0] ctrl_q;
	logic [7:0] start_q;
	logic [7:0] len_q;
	logic [15:0] hold_q;
	logic [7:0] div_q;
	logic [7:0] rdata_q;
	// sequencer state
	pnss_pkg::pnss_state_t state_q;
	pnss_pkg::pnss_state_t state_d;
	logic run_prev_q;
	logic [15:0] shift_q;
	logic [15:0] shift_d;
	localparam logic [15:0] HOLD_ZERO = pnss_pkg::HOLD_RESET;
	logic [3:0] bit_idx_q;
	logic [3:0] bit_idx_d;
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic [7:0] chip_cnt_q;
	logic [7:0] chip_cnt_d;
	logic refill_q;
	// pin drivers
	logic spread_q;
	logic unspread_q;
	logic chip_clk_q;
	logic bit_clk_q;
	logic spread_oe_q;
	logic chip_oe_q;
	logic unspread_oe_q;
	logic bitclk_oe_q;

	// write strobes per register
	wire logic wr_ctrl = reg_wr_in && reg_addr_in == pnss_pkg::OFS_CTRL;
	wire logic wr_start = reg_wr_in && reg_addr_in == pnss_pkg::OFS_START;
	wire logic wr_len = reg_wr_in && reg_addr_in == pnss_pkg::OFS_LEN;
	wire logic wr_hold_lo = reg_wr_in && reg_addr_in == pnss_pkg::OFS_HOLD_LO;
	wire logic wr_hold_hi = reg_wr_in && reg_addr_in == pnss_pkg::OFS_HOLD_HI;
	wire logic wr_div = reg_wr_in && reg_addr_in == pnss_pkg::OFS_DIV;

	// control fields
	wire logic enable = ctrl_q[pnss_pkg::CTRL_EN_BIT];
	wire logic run_bit = ctrl_q[pnss_pkg::CTRL_RUN_BIT];
	wire logic ratio_mode = ctrl_q[pnss_pkg::CTRL_RATIO_BIT];
	wire pnss_pkg::pnss_ref_t ref_sel = pnss_pkg::pnss_ref_t'(ctrl_q[pnss_pkg::CTRL_REF_LSB +: 2]);

	// readback; the shift register is deliberately absent
	wire logic [7:0] rdata_d =
		reg_addr_in == pnss_pkg::OFS_CTRL ? ctrl_q :
		reg_addr_in == pnss_pkg::OFS_START ? start_q :
		reg_addr_in == pnss_pkg::OFS_LEN ? len_q :
		reg_addr_in == pnss_pkg::OFS_HOLD_LO ? hold_q[7:0] :
		reg_addr_in == pnss_pkg::OFS_HOLD_HI ? hold_q[15:8] :
		reg_addr_in == pnss_pkg::OFS_DIV ? div_q : 8'h00;

	// reference tick select; the reserved code gives no ticks at all
	wire logic ref_tick =
		ref_sel == pnss_pkg::PNSS_REF_SYS ? 1'b1 :
		ref_sel == pnss_pkg::PNSS_REF_TIMER0 ? counter_timer_zero_in :
		ref_sel == pnss_pkg::PNSS_REF_TIMER1 ? counter_timer_one_in : 1'b0;

	// run edge; restart also rephases the clock chain so chips line up
	wire logic run_rise = enable && run_bit && !run_prev_q;
	wire logic gen_clear = !enable || run_rise;

	wire logic chip_tick;
	wire logic bit_tick;
	wire logic rom_chip;

	pnss_clock_gen u_clock_gen (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.clear_in(gen_clear),
		.ref_tick_in(ref_tick),
		.ratio_mode_in(ratio_mode),
		.divider_in(div_q),
		.len_in(len_q),
		.chip_tick_out(chip_tick),
		.bit_tick_out(bit_tick)
	);

	pnss_code_rom u_code_rom (
		.addr_in(addr_q),
		.chip_out(rom_chip)
	);

	// word and byte boundary decode
	wire logic running = state_q == pnss_pkg::PNSS_RUN;
	wire logic word_end = bit_idx_q == pnss_pkg::WORD_LAST_BIT;
	wire logic byte_end = bit_idx_q[2:0] == pnss_pkg::BYTE_LAST_BIT;
	wire logic stop_now = running && bit_tick && byte_end && !run_bit;
	wire logic reload = running && bit_tick && word_end && run_bit;
	// last chip of the cycle; length zero wraps after 256 chips
	wire logic code_wrap = chip_cnt_q == len_q - 8'h01;
	wire logic data_bit = shift_q[15];
	wire logic spread_d = code_only_select_in ? rom_chip : rom_chip ^ data_bit;

	// sequencer next state
	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bit_idx_d = bit_idx_q;
		addr_d = addr_q;
		chip_cnt_d = chip_cnt_q;
		if (!enable) begin
			state_d = pnss_pkg::PNSS_IDLE;
			shift_d = HOLD_ZERO;
		end else if (run_rise) begin
			state_d = pnss_pkg::PNSS_ARMED;
			shift_d = hold_q;
			bit_idx_d = 4'h0;
			addr_d = start_q;
			chip_cnt_d = 8'h00;
		end else begin
			unique case (state_q)
				pnss_pkg::PNSS_IDLE: begin
					state_d = pnss_pkg::PNSS_IDLE;
				end
				pnss_pkg::PNSS_ARMED: begin
					// first bit and first chip go out together on the bit tick
					if (!run_bit) begin
						state_d = pnss_pkg::PNSS_IDLE;
						shift_d = HOLD_ZERO;
					end else if (bit_tick) begin
						state_d = pnss_pkg::PNSS_RUN;
					end
				end
				pnss_pkg::PNSS_RUN: begin
					if (stop_now) begin
						state_d = pnss_pkg::PNSS_IDLE;
						shift_d = HOLD_ZERO;
					end else if (reload) begin
						shift_d = hold_q;
						bit_idx_d = 4'h0;
					end else if (bit_tick) begin
						shift_d = {shift_q[14:0], 1'b0};
						bit_idx_d = bit_idx_q + 4'h1;
					end
					// code address walks on chip ticks, independent of data edges
					if (chip_tick && !stop_now) begin
						if (code_wrap) begin
							addr_d = start_q;
							chip_cnt_d = 8'h00;
						end else begin
							addr_d = addr_q + 8'h01;
							chip_cnt_d = chip_cnt_q + 8'h01;
						end
					end
				end
				default: begin
					state_d = pnss_pkg::PNSS_IDLE;
				end
			endcase
		end
	end

	// registers written by the cpu
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_q <= pnss_pkg::REG_RESET;
			start_q <= pnss_pkg::REG_RESET;
			len_q <= pnss_pkg::REG_RESET;
			hold_q <= pnss_pkg::HOLD_RESET;
			div_q <= pnss_pkg::REG_RESET;
			rdata_q <= pnss_pkg::REG_RESET;
		end else begin
			if (wr_ctrl) ctrl_q <= reg_wdata_in;
			if (wr_start) start_q <= reg_wdata_in;
			if (wr_len) len_q <= reg_wdata_in;
			if (wr_hold_lo) hold_q[7:0] <= reg_wdata_in;
			if (wr_hold_hi) hold_q[15:8] <= reg_wdata_in;
			if (wr_div) div_q <= reg_wdata_in;
			rdata_q <= rdata_d;
		end
	end

	// sequencer registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= pnss_pkg::PNSS_IDLE;
			run_prev_q <= 1'b0;
			shift_q <= pnss_pkg::HOLD_RESET;
			bit_idx_q <= 4'h0;
			addr_q <= 8'h00;
			chip_cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			run_prev_q <= run_bit;
			shift_q <= shift_d;
			bit_idx_q <= bit_idx_d;
			addr_q <= addr_d;
			chip_cnt_q <= chip_cnt_d;
		end
	end

	// refill flag: a reload in the clear cycle still sets it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			refill_q <= 1'b0;
		end else if (!enable) begin
			refill_q <= 1'b0;
		end else if (reload) begin
			refill_q <= 1'b1;
		end else if (refill_clear_in) begin
			refill_q <= 1'b0;
		end
	end

	// stream outputs; static low while idle so the transmitter sees no chatter
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			spread_q <= 1'b0;
			unspread_q <= 1'b0;
			chip_clk_q <= 1'b0;
			bit_clk_q <= 1'b0;
		end else begin
			spread_q <= running ? spread_d : 1'b0;
			unspread_q <= running ? data_bit : 1'b0;
			chip_clk_q <= running ? chip_clk_q ^ chip_tick : 1'b0;
			bit_clk_q <= state_q != pnss_pkg::PNSS_IDLE ? bit_clk_q ^ bit_tick : 1'b0;
		end
	end

	// pin enables; port2 pins also need their direction set to output
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			spread_oe_q <= 1'b0;
			chip_oe_q <= 1'b0;
			unspread_oe_q <= 1'b0;
			bitclk_oe_q <= 1'b0;
		end else begin
			spread_oe_q <= enable;
			chip_oe_q <= enable && ctrl_q[pnss_pkg::CTRL_CHIPOUT_BIT];
			unspread_oe_q <= enable && ctrl_q[pnss_pkg::CTRL_UNSPREAD_BIT] &&
				port2_bit0_output_enable_in;
			bitclk_oe_q <= enable && ctrl_q[pnss_pkg::CTRL_BITCLK_BIT] &&
				port2_bit7_output_enable_in;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign refill_request_out = refill_q;
	assign port3_bit5_pin_out = spread_q;
	assign port3_bit5_pin_oe_out = spread_oe_q;
	assign port3_bit6_pin_out = chip_clk_q;
	assign port3_bit6_pin_oe_out = chip_oe_q;
	assign port2_bit0_pin_out = unspread_q;
	assign port2_bit0_pin_oe_out = unspread_oe_q;
	assign port2_bit7_pin_out = bit_clk_q;
	assign port2_bit7_pin_oe_out = bitclk_oe_q;

	// checks on the sequencer and pin muxing
	spread_pin_en_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		port3_bit5_pin_oe_out == $past(enable))
		else $error("spread pin enable does not follow enable bit");

	refill_off_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		!enable |=> !refill_request_out)
		else $error("refill flag set while disabled");

	refill_set_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		reload && enable |=> refill_request_out && shift_q == $past(hold_q))
		else $error("word reload did not raise refill flag");

	refill_clear_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		refill_clear_in && !reload && enable |=> !refill_request_out)
		else $error("refill flag did not clear");

	chip_pin_en_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		port3_bit6_pin_oe_out == $past(enable && ctrl_q[pnss_pkg::CTRL_CHIPOUT_BIT]))
		else $error("chip clock pin enable wrong");

	unspread_pin_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		!port2_bit0_output_enable_in |=> !port2_bit0_pin_oe_out)
		else $error("unspread pin driven while port is an input");

	bitclk_pin_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		!enable || !ctrl_q[pnss_pkg::CTRL_BITCLK_BIT] |=> !port2_bit7_pin_oe_out)
		else $error("bit clock pin driven while not enabled");

	start_load_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		run_rise |=> state_q == pnss_pkg::PNSS_ARMED && addr_q == $past(start_q)
			&& shift_q == $past(hold_q))
		else $error("run start did not load word and offset");

	code_only_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		running && code_only_select_in |=> port3_bit5_pin_out == $past(rom_chip))
		else $error("code-only output is not the raw chip");

	stop_byte_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		running && enable && !run_rise && !byte_end |=> state_q == pnss_pkg::PNSS_RUN)
		else $error("spreading stopped inside a byte");

	stop_flush_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		stop_now && !run_rise |=> state_q == pnss_pkg::PNSS_IDLE && shift_q == 16'h0000
			&& !refill_request_out == !$past(refill_q && !refill_clear_in))
		else $error("stop did not flush without reload");

	code_wrap_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		running && chip_tick && code_wrap && !stop_now && !run_rise && enable
			|=> addr_q == $past(start_q) && chip_cnt_q == 8'h00)
		else $error("code address did not wrap to start offset");

	idle_static_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		!running |=> !port3_bit5_pin_out && !port2_bit0_pin_out)
		else $error("stream outputs toggle while idle");
endmodule

// ==== verif/pnss_tx_model.sv ====
// transmitter-side model: captures the pin streams and counts pin activity
module pnss_tx_model #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic clk_in,
	input wire logic clr_in,
	input wire logic spread_in,
	input wire logic unspread_in,
	input wire logic chip_clk_in,
	input wire logic bit_clk_in,
	output logic [31:0] word_out,
	output logic [7:0] agree_out,
	output logic [7:0] chip_tog_out,
	output logic [7:0] bit_tog_out,
	output logic [7:0] ones_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed = 1'b0;
	logic prev_u = 1'b0;
	logic prev_c = 1'b0;
	logic prev_b = 1'b0;
	int cnt = 0;
	int nbits = 0;
	// activity counters; a window of whole periods gives an exact count at any phase
	always @(posedge clk_in) begin
		prev_c <= chip_clk_in;
		prev_b <= bit_clk_in;
		if (clr_in) begin
			chip_tog_out <= 8'h00;
			bit_tog_out <= 8'h00;
			ones_out <= 8'h00;
		end else begin
			chip_tog_out <= chip_tog_out + 8'(chip_clk_in != prev_c);
			bit_tog_out <= bit_tog_out + 8'(bit_clk_in != prev_b);
			ones_out <= ones_out + 8'(spread_in);
		end
	end
	// a word is framed by the first rise of unspread data after idle low
	always @(posedge clk_in) begin
		prev_u <= unspread_in;
		if (clr_in) begin
			armed <= 1'b1;
			cnt <= 0;
			nbits <= 0;
			agree_out <= 8'h00;
			word_out <= 32'h0000_0000;
		end else if (armed && unspread_in && !prev_u) begin
			armed <= 1'b0;
			cnt <= 1;
		end else if (cnt != 0 && nbits < 32) begin
			// sample mid-bit so a one-cycle skew between pins cannot matter
			if (cnt == BIT_CYCLES / 2) begin
				word_out <= {word_out[30:0], unspread_in};
				nbits <= nbits + 1;
				if (nbits < 24 && spread_in == unspread_in) begin
					agree_out <= agree_out + 8'h01;
				end
			end
			cnt <= (cnt == BIT_CYCLES) ? 1 : cnt + 1;
		end
	end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the spreading modulator
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic code_only = 1'b0;
	logic tmr0_tick = 1'b0;
	logic tmr1_tick = 1'b0;
	logic refill_clear = 1'b0;
	logic ud_dir = 1'b1;
	logic bc_dir = 1'b1;
	logic model_clr = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic [7:0] reg_rdata_out;
	logic refill;
	logic sp_pin, sp_oe, ck_pin, ck_oe, ud_pin, ud_oe, bc_pin, bc_oe;
	logic [31:0] word;
	logic [7:0] agree, chip_tog, bit_tog, ones;
	int failures = 0;
	int n_tests = 0;
	// clock-mode table: control, divider, chip and bit clock pin toggles per 48 cycles
	logic [7:0] m_ctrl [9] = '{8'h79, 8'h79, 8'h79, 8'h79, 8'h79, 8'hF9, 8'h7B, 8'h7D, 8'h7F};
	logic [7:0] m_div [9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h06, 8'h06, 8'h00, 8'h00, 8'h00};
	logic [7:0] m_chip [9] = '{8'h30, 8'h30, 8'h30, 8'h0C, 8'h0C, 8'h30, 8'h18, 8'h0C, 8'h00};
	logic [7:0] m_bit [9] = '{8'h10, 8'h08, 8'h02, 8'h10, 8'h04, 8'h08, 8'h08, 8'h04, 8'h00};

	always #5 clk_in = ~clk_in;
	// timer ticks: zero every second cycle, one every fourth
	always @(negedge clk_in) begin
		tcnt <= tcnt + 2'h1;
		tmr0_tick <= ~tcnt[0];
		tmr1_tick <= (tcnt == 2'h3);
	end

	pnss_spreader dut_u (
		.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
		.code_only_select_in(code_only), .counter_timer_zero_in(tmr0_tick),
		.counter_timer_one_in(tmr1_tick), .refill_clear_in(refill_clear),
		.port2_bit0_output_enable_in(ud_dir), .port2_bit7_output_enable_in(bc_dir),
		.refill_request_out(refill), .port3_bit5_pin_out(sp_pin), .port3_bit5_pin_oe_out(sp_oe),
		.port3_bit6_pin_out(ck_pin), .port3_bit6_pin_oe_out(ck_oe), .port2_bit0_pin_out(ud_pin),
		.port2_bit0_pin_oe_out(ud_oe), .port2_bit7_pin_out(bc_pin), .port2_bit7_pin_oe_out(bc_oe)
	);

	pnss_tx_model #(.BIT_CYCLES(8)) model_u (
		.clk_in(clk_in), .clr_in(model_clr), .spread_in(sp_pin), .unspread_in(ud_pin),
		.chip_clk_in(ck_pin), .bit_clk_in(bc_pin), .word_out(word), .agree_out(agree),
		.chip_tog_out(chip_tog), .bit_tog_out(bit_tog), .ones_out(ones)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// one write: strobe high for exactly one rising edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask

	// readback is registered, so the address is held across one edge first
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(negedge clk_in);
		reg_addr_in = a;
		@(negedge clk_in);
		check(32'(reg_rdata_out), 32'(e));
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk_in);
		s = 1'b1;
		@(negedge clk_in);
		s = 1'b0;
	endtask

	task automatic wait_refill;
		int i;
		for (i = 0; i < 600 && refill !== 1'b1; i++) begin
			@(negedge clk_in);
		end
		if (i == 600) begin
			failures++;
			complete_run();
		end
	endtask

	// hang guard
	initial begin
		repeat (30000) @(posedge clk_in);
		failures++;
		complete_run();
	end

	initial begin
		cyc(10);
		nrst_in = 1'b1;
		for (int a = 0; a < 6; a++) begin
			rd_chk(a[2:0], pnss_pkg::REG_RESET);
		end
		wr(3'h6, 8'hFF);
		rd_chk(3'h6, 8'h00);
		wr(pnss_pkg::OFS_CTRL, 8'hB6);
		rd_chk(pnss_pkg::OFS_CTRL, 8'hB6);
		for (int a = 1; a < 6; a++) begin
			wr(a[2:0], {a[3:0], ~a[3:0]});
			rd_chk(a[2:0], {a[3:0], ~a[3:0]});
		end
		// pin routing needs enable and, for port two, the port direction
		wr(pnss_pkg::OFS_CTRL, 8'h01);
		cyc(2);
		check(32'({sp_oe, ck_oe, ud_oe, bc_oe}), 32'h8);
		wr(pnss_pkg::OFS_CTRL, 8'h39);
		cyc(2);
		check(32'({sp_oe, ck_oe, ud_oe, bc_oe}), 32'hF);
		ud_dir = 1'b0;
		bc_dir = 1'b0;
		cyc(2);
		check(32'({sp_oe, ck_oe, ud_oe, bc_oe}), 32'hC);
		ud_dir = 1'b1;
		bc_dir = 1'b1;
		check(32'({refill, sp_pin, ud_pin}), 32'h0);
		// one-chip code, chip always 1, bit period eight cycles
		wr(pnss_pkg::OFS_LEN, 8'h01);
		wr(pnss_pkg::OFS_START, 8'h00);
		wr(pnss_pkg::OFS_DIV, 8'h03);
		wr(pnss_pkg::OFS_HOLD_LO, 8'h3C);
		wr(pnss_pkg::OFS_HOLD_HI, 8'hA5);
		pulse(model_clr);
		wr(pnss_pkg::OFS_CTRL, 8'h79);
		wr(pnss_pkg::OFS_HOLD_LO, 8'hFF);
		wr(pnss_pkg::OFS_HOLD_HI, 8'hFF);
		wait_refill();
		check(32'(refill), 32'h1);
		// stop request lands in the first byte of the second word
		wr(pnss_pkg::OFS_CTRL, 8'h39);
		pulse(refill_clear);
		check(32'(refill), 32'h0);
		cyc(300);
		check(word, 32'hA53C_FF00);
		check(32'(agree), 32'h0);
		check(32'(refill), 32'h0);
		pulse(model_clr);
		wr(pnss_pkg::OFS_CTRL, 8'h79);
		cyc(300);
		check(word, 32'hFFFF_FFFF);
		check(32'(refill), 32'h1);
		wr(pnss_pkg::OFS_CTRL, 8'h00);
		wr(pnss_pkg::OFS_CTRL, 8'h01);
		check(32'(refill), 32'h0);
		// three-chip code wrapping past the top of the store, raw chips on the pin
		wr(pnss_pkg::OFS_START, 8'hFE);
		wr(pnss_pkg::OFS_LEN, 8'h03);
		code_only = 1'b1;
		for (int m = 0; m < 9; m++) begin
			wr(pnss_pkg::OFS_CTRL, 8'h00);
			wr(pnss_pkg::OFS_DIV, m_div[m]);
			wr(pnss_pkg::OFS_CTRL, m_ctrl[m]);
			cyc(40);
			pulse(model_clr);
			cyc(48);
			check(32'(chip_tog), 32'(m_chip[m]));
			check(32'(bit_tog), 32'(m_bit[m]));
			if (m == 0) begin
				check(32'(ones), 32'h20);
			end
		end
		// disabled: no pin activity at all
		wr(pnss_pkg::OFS_CTRL, 8'h00);
		cyc(4);
		pulse(model_clr);
		cyc(48);
		check(32'({chip_tog, bit_tog, ones}), 32'h0);
		complete_run();
	end
endmodule
